// file: src/mpfs_consts.vh
`ifndef MPFS_CONSTS_VH
`define MPFS_CONSTS_VH

// ==========================================================
// Pin group widths and positions in the flat pin vector
`define MPFS_P7_W      1
`define MPFS_P8_W      6
`define MPFS_PA_W      7
`define MPFS_PB_W      8
`define MPFS_PE_W      8
`define MPFS_PF_W      8
`define MPFS_PIN_W     38
`define MPFS_P7_LO     0
`define MPFS_P8_LO     1
`define MPFS_PA_LO     7
`define MPFS_PB_LO     14
`define MPFS_PE_LO     22
`define MPFS_PF_LO     30

// ==========================================================
// Field positions inside groups
`define MPFS_P8_RDY    0
`define MPFS_P8_WRU    4
`define MPFS_P8_WRL    5
`define MPFS_PA_CS3    3
`define MPFS_PA_CLK    6
`define MPFS_PB_DMA_END_OF_PROCESS_CH2   4
`define MPFS_PB_DMA_REQUEST_IN_CH2  5
`define MPFS_PB_DMA_ACK_OUT_CH2  6
`define MPFS_PE_SC1    2
`define MPFS_PE_SC2    3
`define MPFS_PE_DMA_REQUEST_IN_CH0  4
`define MPFS_PE_DREQ1  5
`define MPFS_PE_DMA_ACK_OUT_CH0  6
`define MPFS_PE_DACK1  7
`define MPFS_PF_RX0    0
`define MPFS_PF_TX0    1
`define MPFS_PF_SC0    2
`define MPFS_PF_RX1    3
`define MPFS_PF_TX1    4
`define MPFS_PF_RX2    5
`define MPFS_PF_TX2    6
`define MPFS_PF_ATG    7

// ==========================================================
// Strap decoding and reset values
`define MPFS_MODE_SINGLE  3'h0
`define MPFS_MODE_RST     3'h0
`define MPFS_PIN_RST      38'h0
`define MPFS_OE_RST       38'h0

`endif

// file: src/mpfs_mode_latch.v
`timescale 1ns/1ps
`include "mpfs_consts.vh"

// ==========================================================
// Strap capture: taken once on the first edge after reset
module mpfs_mode_latch (
  input  wire       sys_clk_i,
  input  wire       arst_n_i,
  input  wire [2:0] boot_mode_strap_i,
  output reg  [2:0] mode_q,
  output reg        valid_q,
  output reg        ext_bus_q
);

  // Straps are static by board design, so one sample suffices
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q    <= `MPFS_MODE_RST;
      valid_q   <= 1'b0;
      ext_bus_q <= 1'b0;
    end else if (!valid_q) begin
      mode_q    <= boot_mode_strap_i;
      valid_q   <= 1'b1;
      ext_bus_q <= (boot_mode_strap_i != `MPFS_MODE_SINGLE);
    end
  end

endmodule

// file: src/mpfs_pin_cell.v
`timescale 1ns/1ps
`include "mpfs_consts.vh"

// ==========================================================
// Per-pin selector, function over port, registered drive
module mpfs_pin_cell (
  input  wire                   sys_clk_i,
  input  wire                   arst_n_i,
  input  wire [`MPFS_PIN_W-1:0] fn_en_i,
  input  wire [`MPFS_PIN_W-1:0] fn_out_i,
  input  wire [`MPFS_PIN_W-1:0] port_out_i,
  input  wire [`MPFS_PIN_W-1:0] port_oe_i,
  output reg  [`MPFS_PIN_W-1:0] pin_q,
  output reg  [`MPFS_PIN_W-1:0] pin_oe_q
);

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q    <= `MPFS_PIN_RST;
      pin_oe_q <= `MPFS_OE_RST;
    end else begin
      pin_q    <= (fn_en_i & fn_out_i) | (~fn_en_i & port_out_i);
      pin_oe_q <= fn_en_i | port_oe_i;
    end
  end

endmodule

// file: src/mpfs_pin_mux.v
`timescale 1ns/1ps
`include "mpfs_consts.vh"

// Operation
// - 16-bit bus: upper strobe high lane, lower strobe low lane; 8-bit frees lower.
// - Lower write strobe pin stays undriven while in reset.
// - Unused write strobe pins act as port bits.
// - Six active-low chip selects; unassigned ones act as port bits.
// - Chip select 3 pin carries end-of-process 1 only when enabled.
// - Clock output follows bus clock when selected, else port bit.
// - Port B carries DRAM strobes of two banks, else port bits.
// - Bank B row strobe pin carries end-of-process 2 when enabled.
// - DMA request pins sampled while selected as transfer cause.
// - DMA acknowledges driven only while acknowledge output enabled.
// - External interrupt inputs monitored while their interrupt is enabled.
// - Serial clock pin driven while clock output enabled, else serial clock 0 pin carries PWM output 3 when PWM output enabled.
// - Trigger beside serial 1 data out valid only when both outputs off.
// - Serial 2 data out driven only while enabled, else PWM output 2 when PWM output enabled, else port.
// - Serial 2 receive input sampled while receiving.
// - Serial 0/1 receive and shared triggers sampled when selected.
// - PWM outputs appear only while PWM output enabled.
// - Active-low converter trigger monitored when selected as start cause.
// - Enabled peripheral output beats port output on a shared pin.
// - Nonmaskable interrupt pin is active-low request input.
module mpfs_pin_mux (
  input  wire       sys_clk_i,
  input  wire       arst_n_i,
  input  wire [2:0] boot_mode_strap_i,
  input  wire       nonmaskable_irq_n_i,
  input  wire       bus_width16_i,
  input  wire       bus_wr_active_n_i,
  input  wire       bus_lane_hi_i,
  input  wire       bus_lane_lo_i,
  input  wire       bus_ready_en_i,
  input  wire       addr24_en_i,
  input  wire       addr24_i,
  input  wire [5:0] chip_sel_en_i,
  input  wire [5:0] chip_sel_n_i,
  input  wire       bus_clk_out_en_i,
  input  wire       bus_clk_level_i,
  input  wire [7:0] dram_fn_en_i,
  input  wire [7:0] dram_strobe_i,
  input  wire       dma_eop_out_en_i,
  input  wire [2:0] dma_end_of_process_i,
  input  wire       dma_ack_out_en_i,
  input  wire [2:0] dma_ack_i,
  input  wire [2:0] dma_req_sel_i,
  input  wire [3:0] ext_irq_en_i,
  input  wire [2:0] ser_clk_out_en_i,
  input  wire [2:0] ser_clk_i,
  input  wire [2:0] ser_tx_en_i,
  input  wire [2:0] ser_tx_i,
  input  wire [2:0] ser_rx_en_i,
  input  wire       pwm_out_en_i,
  input  wire [3:0] pwm_out_i,
  input  wire [3:0] pwm_trig_sel_i,
  input  wire       adc_trig_sel_i,
  input  wire [0:0] p7_pin_i,
  input  wire [0:0] p7_port_out_i,
  input  wire [0:0] p7_port_oe_i,
  input  wire [5:0] p8_pin_i,
  input  wire [5:0] p8_port_out_i,
  input  wire [5:0] p8_port_oe_i,
  input  wire [6:0] pa_pin_i,
  input  wire [6:0] pa_port_out_i,
  input  wire [6:0] pa_port_oe_i,
  input  wire [7:0] pb_pin_i,
  input  wire [7:0] pb_port_out_i,
  input  wire [7:0] pb_port_oe_i,
  input  wire [7:0] pe_pin_i,
  input  wire [7:0] pe_port_out_i,
  input  wire [7:0] pe_port_oe_i,
  input  wire [7:0] pf_pin_i,
  input  wire [7:0] pf_port_out_i,
  input  wire [7:0] pf_port_oe_i,
  output wire [0:0] p7_pin_o,
  output wire [0:0] p7_pin_oe_o,
  output wire [5:0] p8_pin_o,
  output wire [5:0] p8_pin_oe_o,
  output wire [6:0] pa_pin_o,
  output wire [6:0] pa_pin_oe_o,
  output wire [7:0] pb_pin_o,
  output wire [7:0] pb_pin_oe_o,
  output wire [7:0] pe_pin_o,
  output wire [7:0] pe_pin_oe_o,
  output wire [7:0] pf_pin_o,
  output wire [7:0] pf_pin_oe_o,
  output reg  [0:0] p7_port_in_o,
  output reg  [5:0] p8_port_in_o,
  output reg  [6:0] pa_port_in_o,
  output reg  [7:0] pb_port_in_o,
  output reg  [7:0] pe_port_in_o,
  output reg  [7:0] pf_port_in_o,
  output wire [2:0] boot_mode_o,
  output wire       ext_bus_mode_o,
  output reg        nmi_req_o,
  output reg        bus_ready_o,
  output reg  [2:0] dma_req_o,
  output reg  [3:0] ext_irq_o,
  output reg  [2:0] ser_rx_o,
  output reg  [2:0] ser_clk_in_o,
  output reg  [3:0] pwm_trig_o,
  output reg        adc_ext_trigger_n_o
);

  // ==========================================================
  // Mode straps
  wire       mode_valid;
  wire       ext_bus;

  mpfs_mode_latch u_mode (
    .sys_clk_i         (sys_clk_i),
    .arst_n_i          (arst_n_i),
    .boot_mode_strap_i (boot_mode_strap_i),
    .mode_q            (boot_mode_o),
    .valid_q           (mode_valid),
    .ext_bus_q         (ext_bus)
  );

  assign ext_bus_mode_o = ext_bus;

  // ==========================================================
  // Write strobes
  wire wr_act;
  wire wr_upper_en;
  wire wr_lower_en;
  wire write_strobe_upper_n;
  wire write_strobe_lower_n;

  assign wr_act = ~bus_wr_active_n_i;
  // In 8-bit mode every byte travels on the upper strobe
  assign write_strobe_upper_n = ~(wr_act & (bus_width16_i ? bus_lane_hi_i
                                : (bus_lane_hi_i | bus_lane_lo_i)));
  assign write_strobe_lower_n = ~(wr_act & bus_lane_lo_i);
  // Lower strobe held off until straps are known, so it floats in reset
  assign wr_upper_en = mode_valid & ext_bus;
  assign wr_lower_en = mode_valid & ext_bus & bus_width16_i;

  // ==========================================================
  // Port 7: address bit 24 and end-of-process 0
  wire [0:0] p7_en;
  wire [0:0] p7_out;

  assign p7_en  = dma_eop_out_en_i | addr24_en_i;
  assign p7_out = dma_eop_out_en_i ? dma_end_of_process_i[0] : addr24_i;

  // ==========================================================
  // Port 8: ready input and write strobes
  wire [5:0] p8_en;
  wire [5:0] p8_out;

  assign p8_en  = {wr_lower_en, wr_upper_en, 4'h0};
  assign p8_out = {write_strobe_lower_n, write_strobe_upper_n, 4'h0};

  // ==========================================================
  // Port A: chip selects and bus clock
  reg [6:0] pa_en;
  reg [6:0] pa_out;

  always @* begin
    pa_en  = {bus_clk_out_en_i, chip_sel_en_i};
    pa_out = {bus_clk_level_i, chip_sel_n_i};
    // End-of-process wins the shared pin only while enabled
    if (dma_eop_out_en_i) begin
      pa_en[`MPFS_PA_CS3]  = 1'b1;
      pa_out[`MPFS_PA_CS3] = dma_end_of_process_i[1];
    end
  end

  // ==========================================================
  // Port B: DRAM strobes for two banks
  reg [7:0] pb_en;
  reg [7:0] pb_out;

  always @* begin
    pb_en  = dram_fn_en_i;
    pb_out = dram_strobe_i;
    if (dma_eop_out_en_i) begin
      pb_en[`MPFS_PB_DMA_END_OF_PROCESS_CH2]  = 1'b1;
      pb_out[`MPFS_PB_DMA_END_OF_PROCESS_CH2] = dma_end_of_process_i[2];
    end
    if (dma_ack_out_en_i) begin
      pb_en[`MPFS_PB_DMA_ACK_OUT_CH2]  = 1'b1;
      pb_out[`MPFS_PB_DMA_ACK_OUT_CH2] = dma_ack_i[2];
    end
    // Request input: DRAM drive is dropped while selected as a cause
    if (dma_req_sel_i[2]) begin
      pb_en[`MPFS_PB_DMA_REQUEST_IN_CH2] = 1'b0;
    end
  end

  // ==========================================================
  // Port E: interrupts, serial clocks, DMA request and acknowledge
  reg [7:0] pe_en;
  reg [7:0] pe_out;

  always @* begin
    pe_en  = 8'h00;
    pe_out = 8'h00;
    pe_en[`MPFS_PE_SC1]    = ser_clk_out_en_i[1];
    pe_out[`MPFS_PE_SC1]   = ser_clk_i[1];
    pe_en[`MPFS_PE_SC2]    = ser_clk_out_en_i[2];
    pe_out[`MPFS_PE_SC2]   = ser_clk_i[2];
    pe_en[`MPFS_PE_DMA_ACK_OUT_CH0]  = dma_ack_out_en_i;
    pe_out[`MPFS_PE_DMA_ACK_OUT_CH0] = dma_ack_i[0];
    pe_en[`MPFS_PE_DACK1]  = dma_ack_out_en_i;
    pe_out[`MPFS_PE_DACK1] = dma_ack_i[1];
  end

  // ==========================================================
  // Port F: serial data, PWM and converter trigger
  reg [7:0] pf_en;
  reg [7:0] pf_out;

  always @* begin
    pf_en  = 8'h00;
    pf_out = 8'h00;
    // Receive 0/1 pins, which carry triggers 0 and 2, get no peripheral drive at all
    pf_en[`MPFS_PF_RX0] = 1'b0;
    pf_en[`MPFS_PF_RX1] = 1'b0;
    pf_en[`MPFS_PF_TX0]  = ser_tx_en_i[0];
    pf_out[`MPFS_PF_TX0] = ser_tx_i[0];
    pf_en[`MPFS_PF_TX1]  = ser_tx_en_i[1];
    pf_out[`MPFS_PF_TX1] = ser_tx_i[1];
    // Serial clock outranks PWM output 3 on the same pin
    if (ser_clk_out_en_i[0]) begin
      pf_en[`MPFS_PF_SC0]  = 1'b1;
      pf_out[`MPFS_PF_SC0] = ser_clk_i[0];
    end else if (pwm_out_en_i) begin
      pf_en[`MPFS_PF_SC0]  = 1'b1;
      pf_out[`MPFS_PF_SC0] = pwm_out_i[3];
    end
    if (pwm_out_en_i && !ser_rx_en_i[2]) begin
      pf_en[`MPFS_PF_RX2]  = 1'b1;
      pf_out[`MPFS_PF_RX2] = pwm_out_i[1];
    end
    if (ser_tx_en_i[2]) begin
      pf_en[`MPFS_PF_TX2]  = 1'b1;
      pf_out[`MPFS_PF_TX2] = ser_tx_i[2];
    end else if (pwm_out_en_i) begin
      pf_en[`MPFS_PF_TX2]  = 1'b1;
      pf_out[`MPFS_PF_TX2] = pwm_out_i[2];
    end
    if (pwm_out_en_i && !adc_trig_sel_i) begin
      pf_en[`MPFS_PF_ATG]  = 1'b1;
      pf_out[`MPFS_PF_ATG] = pwm_out_i[0];
    end
  end

  // ==========================================================
  // Output selection and registered pin drive
  wire [`MPFS_PIN_W-1:0] fn_en;
  wire [`MPFS_PIN_W-1:0] fn_out;
  wire [`MPFS_PIN_W-1:0] prt_out;
  wire [`MPFS_PIN_W-1:0] prt_oe;
  wire [`MPFS_PIN_W-1:0] pin_q;
  wire [`MPFS_PIN_W-1:0] pin_oe_q;

  assign fn_en   = {pf_en, pe_en, pb_en, pa_en, p8_en, p7_en};
  assign fn_out  = {pf_out, pe_out, pb_out, pa_out, p8_out, p7_out};
  assign prt_out = {pf_port_out_i, pe_port_out_i, pb_port_out_i,
                    pa_port_out_i, p8_port_out_i, p7_port_out_i};
  assign prt_oe  = {pf_port_oe_i, pe_port_oe_i, pb_port_oe_i,
                    pa_port_oe_i, p8_port_oe_i, p7_port_oe_i};

  mpfs_pin_cell u_cell (
    .sys_clk_i  (sys_clk_i),
    .arst_n_i   (arst_n_i),
    .fn_en_i    (fn_en),
    .fn_out_i   (fn_out),
    .port_out_i (prt_out),
    .port_oe_i  (prt_oe),
    .pin_q      (pin_q),
    .pin_oe_q   (pin_oe_q)
  );

  assign p7_pin_o    = pin_q[`MPFS_P8_LO-1:`MPFS_P7_LO];
  assign p7_pin_oe_o = pin_oe_q[`MPFS_P8_LO-1:`MPFS_P7_LO];
  assign p8_pin_o    = pin_q[`MPFS_PA_LO-1:`MPFS_P8_LO];
  assign p8_pin_oe_o = pin_oe_q[`MPFS_PA_LO-1:`MPFS_P8_LO];
  assign pa_pin_o    = pin_q[`MPFS_PB_LO-1:`MPFS_PA_LO];
  assign pa_pin_oe_o = pin_oe_q[`MPFS_PB_LO-1:`MPFS_PA_LO];
  assign pb_pin_o    = pin_q[`MPFS_PE_LO-1:`MPFS_PB_LO];
  assign pb_pin_oe_o = pin_oe_q[`MPFS_PE_LO-1:`MPFS_PB_LO];
  assign pe_pin_o    = pin_q[`MPFS_PF_LO-1:`MPFS_PE_LO];
  assign pe_pin_oe_o = pin_oe_q[`MPFS_PF_LO-1:`MPFS_PE_LO];
  assign pf_pin_o    = pin_q[`MPFS_PIN_W-1:`MPFS_PF_LO];
  assign pf_pin_oe_o = pin_oe_q[`MPFS_PIN_W-1:`MPFS_PF_LO];

  // ==========================================================
  // Input routing toward peripherals and port readback
  // Trigger 1 and 3 share pins with data outputs, so both must be off
  wire trg1_ok;
  wire pwm_trigger_in_3_ok;

  assign trg1_ok = ~ser_tx_en_i[0] & ~pf_port_oe_i[`MPFS_PF_TX0];
  assign pwm_trigger_in_3_ok = ~ser_tx_en_i[1] & ~pf_port_oe_i[`MPFS_PF_TX1];

  // Deselected inputs read inactive so a port toggle cannot fake events
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p7_port_in_o        <= 1'h0;
      p8_port_in_o        <= 6'h00;
      pa_port_in_o        <= 7'h00;
      pb_port_in_o        <= 8'h00;
      pe_port_in_o        <= 8'h00;
      pf_port_in_o        <= 8'h00;
      nmi_req_o           <= 1'b0;
      bus_ready_o         <= 1'b1;
      dma_req_o           <= 3'h0;
      ext_irq_o           <= 4'h0;
      ser_rx_o            <= 3'h7;
      ser_clk_in_o        <= 3'h0;
      pwm_trig_o          <= 4'h0;
      adc_ext_trigger_n_o <= 1'b1;
    end else begin
      p7_port_in_o <= p7_pin_i;
      p8_port_in_o <= p8_pin_i;
      pa_port_in_o <= pa_pin_i;
      pb_port_in_o <= pb_pin_i;
      pe_port_in_o <= pe_pin_i;
      pf_port_in_o <= pf_pin_i;
      nmi_req_o    <= ~nonmaskable_irq_n_i;
      bus_ready_o  <= ~bus_ready_en_i | p8_pin_i[`MPFS_P8_RDY];
      dma_req_o    <= dma_req_sel_i & {pb_pin_i[`MPFS_PB_DMA_REQUEST_IN_CH2],
                      pe_pin_i[`MPFS_PE_DREQ1],
                      pe_pin_i[`MPFS_PE_DMA_REQUEST_IN_CH0]};
      ext_irq_o    <= ext_irq_en_i & pe_pin_i[3:0];
      ser_rx_o[0]  <= ~ser_rx_en_i[0] | pf_pin_i[`MPFS_PF_RX0];
      ser_rx_o[1]  <= ~ser_rx_en_i[1] | pf_pin_i[`MPFS_PF_RX1];
      ser_rx_o[2]  <= ~ser_rx_en_i[2] | pf_pin_i[`MPFS_PF_RX2];
      ser_clk_in_o <= ~ser_clk_out_en_i & {pe_pin_i[`MPFS_PE_SC2],
                      pe_pin_i[`MPFS_PE_SC1],
                      pf_pin_i[`MPFS_PF_SC0]};
      pwm_trig_o[0] <= pwm_trig_sel_i[0] & pf_pin_i[`MPFS_PF_RX0];
      pwm_trig_o[1] <= pwm_trig_sel_i[1] & trg1_ok
                       & pf_pin_i[`MPFS_PF_TX0];
      pwm_trig_o[2] <= pwm_trig_sel_i[2] & pf_pin_i[`MPFS_PF_RX1];
      pwm_trig_o[3] <= pwm_trig_sel_i[3] & pwm_trigger_in_3_ok
                       & pf_pin_i[`MPFS_PF_TX1];
      adc_ext_trigger_n_o <= ~adc_trig_sel_i
                             | pf_pin_i[`MPFS_PF_ATG];
    end
  end

endmodule

// file: verification/mpfs_board_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board side of the shared pins
module mpfs_board_model (
  input  wire        sys_clk_i,
  input  wire [37:0] pin_i,
  input  wire [37:0] pin_oe_i,
  input  wire [37:0] drv_en_i,
  input  wire [37:0] drv_val_i,
  output wire [37:0] pad_o
);
  // Lower strobe has the board pull-up; other released pins wander
  localparam [37:0] PULL_UP = 38'h40;
  reg  [37:0] flt_q = 38'h0;
  // Board drives only where the device has let go
  wire [37:0] ext_w = ~pin_oe_i & drv_en_i;
  assign pad_o = (pin_oe_i & pin_i) | (ext_w & drv_val_i)
               | (~pin_oe_i & ~drv_en_i & (flt_q | PULL_UP));
  // Falling edge, so pad sampling never races the wander
  always @(negedge sys_clk_i) flt_q <= ~pad_o;
endmodule

// file: verification/mpfs_pin_mux_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the pin mux
module mpfs_pin_mux_properties (
  input wire       sys_clk_i,
  input wire       arst_n_i,
  input wire       nonmaskable_irq_n_i,
  input wire       bus_clk_out_en_i,
  input wire       bus_clk_level_i,
  input wire       dma_eop_out_en_i,
  input wire [2:0] dma_end_of_process_i,
  input wire       dma_ack_out_en_i,
  input wire [2:0] dma_ack_i,
  input wire [5:0] chip_sel_en_i,
  input wire [5:0] chip_sel_n_i,
  input wire [2:0] ser_clk_out_en_i,
  input wire [7:0] pe_port_out_i,
  input wire [7:0] pe_port_oe_i,
  input wire       adc_trig_sel_i,
  input wire [5:0] p8_pin_oe_o,
  input wire [6:0] pa_pin_o,
  input wire [6:0] pa_pin_oe_o,
  input wire [7:0] pb_pin_o,
  input wire [7:0] pe_pin_o,
  input wire [7:0] pe_pin_oe_o,
  input wire       nmi_req_o,
  input wire       adc_ext_trigger_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_strobe_float;
    $rose(arst_n_i) |-> !p8_pin_oe_o[5];
  endproperty
  a_strobe_float: assert property (p_strobe_float)
    else $error("lower strobe driven at reset exit");
  property p_cs;
    chip_sel_en_i[0] |=> pa_pin_oe_o[0] && pa_pin_o[0] == $past(chip_sel_n_i[0]);
  endproperty
  a_cs: assert property (p_cs)
    else $error("chip select 0 wrong");
  property p_dma_end_of_process_ch1;
    dma_eop_out_en_i |=> pa_pin_o[3] == $past(dma_end_of_process_i[1]);
  endproperty
  a_dma_end_of_process_ch1: assert property (p_dma_end_of_process_ch1)
    else $error("end of process 1 wrong");
  property p_dma_end_of_process_ch2;
    dma_eop_out_en_i |-> ##1 pb_pin_o[4] == $past(dma_end_of_process_i[2]);
  endproperty
  a_dma_end_of_process_ch2: assert property (p_dma_end_of_process_ch2)
    else $error("end of process 2 wrong");
  property p_clk;
    bus_clk_out_en_i |=> pa_pin_o[6] == $past(bus_clk_level_i);
  endproperty
  a_clk: assert property (p_clk)
    else $error("clock out wrong");
  property p_ack;
    dma_ack_out_en_i |=> pe_pin_oe_o[6] && pe_pin_o[6] == $past(dma_ack_i[0]);
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge 0 wrong");
  property p_port;
    !ser_clk_out_en_i[1] |=> pe_pin_o[2] == $past(pe_port_out_i[2])
      && pe_pin_oe_o[2] == $past(pe_port_oe_i[2]);
  endproperty
  a_port: assert property (p_port)
    else $error("port bit not on pin");
  property p_nmi;
    1'b1 |=> nmi_req_o == !$past(nonmaskable_irq_n_i);
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi request wrong");
  property p_adc;
    !adc_trig_sel_i |=> adc_ext_trigger_n_o;
  endproperty
  a_adc: assert property (p_adc)
    else $error("converter trigger not idle");
  c_eop_cs: cover property (dma_eop_out_en_i && chip_sel_en_i[3]);
  c_sclk: cover property (ser_clk_out_en_i[1]);
  c_rst: cover property ($rose(arst_n_i));
endmodule

bind mpfs_pin_mux mpfs_pin_mux_properties u_props (.*);

// file: verification/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Random pin mux bench against a bench-side model
module testbench;
  reg         sys_clk_i, arst_n_i, nonmaskable_irq_n_i, bus_width16_i;
  reg         bus_wr_active_n_i, bus_lane_hi_i, bus_lane_lo_i, bus_ready_en_i;
  reg         addr24_en_i, addr24_i, bus_clk_out_en_i, bus_clk_level_i;
  reg         dma_eop_out_en_i, dma_ack_out_en_i, pwm_out_en_i, adc_trig_sel_i;
  reg [2:0]   boot_mode_strap_i, dma_end_of_process_i, dma_ack_i, ser_tx_i;
  reg [2:0]   dma_req_sel_i, ser_clk_out_en_i, ser_clk_i, ser_tx_en_i;
  reg [2:0]   ser_rx_en_i;
  reg [3:0]   ext_irq_en_i, pwm_out_i, pwm_trig_sel_i;
  reg [5:0]   chip_sel_en_i, chip_sel_n_i;
  reg [7:0]   dram_fn_en_i, dram_strobe_i;
  reg [37:0]  p_out, p_oe, drv_en, drv_val, x_o, x_oe, m;
  reg [54:0]  x_in;
  reg [2:0]   x_clk;
  reg [159:0] rnd;
  integer     n_fail, n_tests, ph, k;
  wire [0:0]  p7_pin_i, p7_port_out_i, p7_port_oe_i, p7_pin_o, p7_pin_oe_o;
  wire [5:0]  p8_pin_i, p8_port_out_i, p8_port_oe_i, p8_pin_o, p8_pin_oe_o;
  wire [6:0]  pa_pin_i, pa_port_out_i, pa_port_oe_i, pa_pin_o, pa_pin_oe_o;
  wire [7:0]  pb_pin_i, pb_port_out_i, pb_port_oe_i, pb_pin_o, pb_pin_oe_o;
  wire [7:0]  pe_pin_i, pe_port_out_i, pe_port_oe_i, pe_pin_o, pe_pin_oe_o;
  wire [7:0]  pf_pin_i, pf_port_out_i, pf_port_oe_i, pf_pin_o, pf_pin_oe_o;
  wire [0:0]  p7_port_in_o;
  wire [5:0]  p8_port_in_o;
  wire [6:0]  pa_port_in_o;
  wire [7:0]  pb_port_in_o, pe_port_in_o, pf_port_in_o;
  wire [2:0]  boot_mode_o, dma_req_o, ser_rx_o, ser_clk_in_o;
  wire [3:0]  ext_irq_o, pwm_trig_o;
  wire        ext_bus_mode_o, nmi_req_o, bus_ready_o, adc_ext_trigger_n_o;
  wire [37:0] pad, pin_o, pin_oe, port_in;
  wire [54:0] in_seen;
  assign {pf_port_out_i, pe_port_out_i, pb_port_out_i, pa_port_out_i,
          p8_port_out_i, p7_port_out_i} = p_out;
  assign {pf_port_oe_i, pe_port_oe_i, pb_port_oe_i, pa_port_oe_i,
          p8_port_oe_i, p7_port_oe_i} = p_oe;
  assign {pf_pin_i, pe_pin_i, pb_pin_i, pa_pin_i, p8_pin_i, p7_pin_i} = pad;
  assign pin_o = {pf_pin_o, pe_pin_o, pb_pin_o, pa_pin_o, p8_pin_o, p7_pin_o};
  assign pin_oe = {pf_pin_oe_o, pe_pin_oe_o, pb_pin_oe_o, pa_pin_oe_o,
                   p8_pin_oe_o, p7_pin_oe_o};
  assign port_in = {pf_port_in_o, pe_port_in_o, pb_port_in_o, pa_port_in_o,
                    p8_port_in_o, p7_port_in_o};
  assign in_seen = {nmi_req_o, bus_ready_o, dma_req_o, ext_irq_o, ser_rx_o,
                    pwm_trig_o, adc_ext_trigger_n_o, port_in};

  mpfs_pin_mux dut (.*);
  mpfs_board_model board (
    .sys_clk_i (sys_clk_i),
    .pin_i     (pin_o),
    .pin_oe_i  (pin_oe),
    .drv_en_i  (drv_en),
    .drv_val_i (drv_val),
    .pad_o     (pad)
  );

  // ==========================================================
  // Tasks
  task check(input logic [63:0] seen, input logic [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task fn(input integer i, input reg en, input reg v);
    begin
      if (en) begin
        x_o[i]  = v;
        x_oe[i] = 1'b1;
      end
    end
  endtask

  // Later calls win, so priority follows call order
  task model;
    integer i;
    reg     up_n, lo_n, ext;
    begin
      ext  = boot_mode_strap_i != 3'h0;
      up_n = ~(~bus_wr_active_n_i & (bus_lane_hi_i
             | (~bus_width16_i & bus_lane_lo_i)));
      lo_n = ~(~bus_wr_active_n_i & bus_lane_lo_i);
      x_o  = p_out;
      x_oe = p_oe;
      fn(0, addr24_en_i, addr24_i);
      fn(0, dma_eop_out_en_i, dma_end_of_process_i[0]);
      fn(5, ext, up_n);
      fn(6, ext & bus_width16_i, lo_n);
      for (i = 0; i < 6; i = i + 1)
        fn(7 + i, chip_sel_en_i[i], chip_sel_n_i[i]);
      fn(10, dma_eop_out_en_i, dma_end_of_process_i[1]);
      fn(13, bus_clk_out_en_i, bus_clk_level_i);
      for (i = 0; i < 8; i = i + 1)
        fn(14 + i, dram_fn_en_i[i] & ~(i == 5 & dma_req_sel_i[2]),
           dram_strobe_i[i]);
      fn(18, dma_eop_out_en_i, dma_end_of_process_i[2]);
      fn(20, dma_ack_out_en_i, dma_ack_i[2]);
      fn(24, ser_clk_out_en_i[1], ser_clk_i[1]);
      fn(25, ser_clk_out_en_i[2], ser_clk_i[2]);
      fn(28, dma_ack_out_en_i, dma_ack_i[0]);
      fn(29, dma_ack_out_en_i, dma_ack_i[1]);
      fn(31, ser_tx_en_i[0], ser_tx_i[0]);
      fn(32, pwm_out_en_i, pwm_out_i[3]);
      fn(32, ser_clk_out_en_i[0], ser_clk_i[0]);
      fn(34, ser_tx_en_i[1], ser_tx_i[1]);
      fn(35, pwm_out_en_i & ~ser_rx_en_i[2], pwm_out_i[1]);
      fn(36, pwm_out_en_i, pwm_out_i[2]);
      fn(36, ser_tx_en_i[2], ser_tx_i[2]);
      fn(37, pwm_out_en_i & ~adc_trig_sel_i, pwm_out_i[0]);
      // Ready pin drive is not defined while its function is on
      m = bus_ready_en_i ? ~38'h2 : ~38'h0;
      x_in = {~nonmaskable_irq_n_i, bus_ready_en_i ? pad[1] : 1'b1,
              dma_req_sel_i & {pad[19], pad[27], pad[26]},
              ext_irq_en_i & pad[25:22],
              ~ser_rx_en_i | {pad[35], pad[33], pad[30]},
              pwm_trig_sel_i & {pad[34] & ~ser_tx_en_i[1] & ~p_oe[34],
              pad[33], pad[31] & ~ser_tx_en_i[0] & ~p_oe[31], pad[30]},
              ~adc_trig_sel_i | pad[37], pad};
      x_clk = ~ser_clk_out_en_i & {pad[25], pad[24], pad[32]};
    end
  endtask

  task drive;
    begin
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
      {nonmaskable_irq_n_i, bus_width16_i, bus_wr_active_n_i, bus_lane_hi_i,
       bus_lane_lo_i, bus_ready_en_i, addr24_en_i, addr24_i, bus_clk_out_en_i,
       bus_clk_level_i, dma_eop_out_en_i, dma_ack_out_en_i, pwm_out_en_i,
       adc_trig_sel_i, dma_end_of_process_i, dma_ack_i, ser_tx_i,
       dma_req_sel_i, ser_clk_out_en_i, ser_clk_i, ser_tx_en_i, ser_rx_en_i,
       ext_irq_en_i, pwm_out_i, pwm_trig_sel_i, chip_sel_en_i, chip_sel_n_i,
       dram_fn_en_i, dram_strobe_i} = rnd[77:0];
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
      {p_out, p_oe, drv_en, drv_val} = rnd[151:0];
    end
  endtask

  task final_report;
    begin
      if (n_fail == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ==========================================================
  // Clock and sequence
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    arst_n_i = 1'b0;
    boot_mode_strap_i = 3'h0;
    rnd[31:0] = $urandom(32'h3ecd);
    drive;
    for (ph = 0; ph < 3; ph = ph + 1) begin
      @(negedge sys_clk_i);
      arst_n_i = 1'b0;
      drv_en = 38'h0;
      boot_mode_strap_i = 3'(ph * 5);
      repeat (6) @(negedge sys_clk_i);
      check(pin_oe, 38'h0);
      check(pad[6], 1'b1);
      arst_n_i = 1'b1;
      for (k = 0; k < 400; k = k + 1) begin
        @(negedge sys_clk_i);
        if (k > 1) begin
          check(pin_o & m, x_o & m);
          check(pin_oe & m, x_oe & m);
          check(in_seen, x_in);
          check(ser_clk_in_o, x_clk);
        end
        drive;
        #1;
        model;
      end
      check({ext_bus_mode_o, boot_mode_o},
            {boot_mode_strap_i != 3'h0, boot_mode_strap_i});
    end
    final_report;
  end
endmodule
